/* rtl/mieu_params.svh */
/*
  Constants of the instruction execute unit: register offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by the unit itself and by the bench.
*/
`ifndef MIEU_PARAMS_SVH
`define MIEU_PARAMS_SVH
// Register byte offsets
`define MIEU_OFS_INSTR   8'h00
`define MIEU_OFS_STATUS  8'h04
`define MIEU_OFS_ACC     8'h08
`define MIEU_OFS_PC      8'h0C
`define MIEU_OFS_TABLE_HIGH_BYTE    8'h10
`define MIEU_OFS_MADDR   8'h14
`define MIEU_OFS_MDATA   8'h18
// Instruction word fields
`define MIEU_F_OP_LSB    0
`define MIEU_F_BIT_LSB   6
`define MIEU_F_MADR_LSB  10
`define MIEU_F_IMM_LSB   16
// Status bits
`define MIEU_ST_GIE      6
`define MIEU_ST_BUSY     8
`define MIEU_ST_HALT     9
`define MIEU_ST_PRE1     10
`define MIEU_ST_PRE2     11
// Data memory slot that aliases the low program counter byte
`define MIEU_PCL_ADDR    6'h06
// Reset values
`define MIEU_RST_ACC     8'h00
`define MIEU_RST_PC      11'h000
`define MIEU_RST_FLAGS   6'h00
// Timing: system clocks per machine cycle
`define MIEU_MCYC_CLKS   4
`endif

/* rtl/mieu_pkg.sv */
/*
  Types of the instruction execute unit.
  Assumes mieu_params.svh on the include path.
*/
`default_nettype none
package mieu_pkg;
  typedef enum logic [5:0] {
    OP_NOP  = 6'h00, OP_JMP  = 6'h01, OP_SZ   = 6'h02, OP_SZA  = 6'h03,
    OP_SZB  = 6'h04, OP_SNZB = 6'h05, OP_SIZ  = 6'h06, OP_SDZ  = 6'h07,
    OP_INCR_SKIP_RESULT_TO_ACCUMULATOR = 6'h08, OP_DECR_SKIP_RESULT_TO_ACCUMULATOR = 6'h09, OP_CALL = 6'h0A, OP_RET  = 6'h0B,
    OP_RETA = 6'h0C, OP_IRQ_EXIT = 6'h0D, OP_TABC = 6'h0E, OP_TABL = 6'h0F,
    OP_CLR  = 6'h10, OP_SET  = 6'h11, OP_CLRB = 6'h12, OP_WDT  = 6'h13,
    OP_WDT1 = 6'h14, OP_WDT2 = 6'h15, OP_SWAP = 6'h16, OP_SWPA = 6'h17,
    OP_HALT = 6'h18, OP_ADC  = 6'h19, OP_ADD_WITH_CARRY_TO_MEMORY = 6'h1A, OP_ADD  = 6'h1B,
    OP_ADDI = 6'h1C, OP_SUM_INTO_MEMORY = 6'h1D, OP_AND  = 6'h1E, OP_ANDI = 6'h1F,
    OP_BITAND_INTO_MEMORY = 6'h20
  } mieu_op_t;

  typedef struct packed {
    logic to;
    logic powerdown_flag;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } mieu_flags_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } mieu_state_t;
endpackage
`default_nettype wire

/* rtl/mieu_core.sv */
/*
  Instruction execute unit with an APB register slave, 64-byte data memory,
  6-level stack and a 14-bit program memory read port for table fetches.
  Assumes program memory answers rom_data one clock after rom_addr changes,
  on the same clock as pclk; the watchdog counter sits outside.
*/
// Decided for this implementation: the APB register port and the address map.
// Summary of operation
// - Zero and bit tests skip the next instruction when true; one cycle otherwise.
// - Increment/decrement skip writes memory back, skips on zero, adds both extras.
// - Accumulator forms of increment/decrement skip load the accumulator, skip on zero.
// - A taken skip adds one machine cycle of four clocks.
// - Writing the low program counter byte adds one machine cycle.
// - Jump loads the target, takes two cycles, flags unchanged.
// - Call pushes program counter plus one, loads target, two cycles.
// - Returns pop the program counter in two cycles, flags unchanged.
// - Table fetches write low byte to memory, upper bits to table high.
// - Clearing a byte writes zero and leaves flags alone.
// - Bit clear zeroes only the selected bit, flags unchanged.
// - Single watchdog clear resets counter and clears both flags.
// - Preclear pair clears watchdog and flags only when both have run.
// - Nibble swap exchanges halves; accumulator form leaves memory and flags.
// - Power-down takes one cycle and updates both flags.
// - Add with carry sums accumulator, byte and carry; updates four flags.
// - Plain add stores sum in accumulator or memory; four flags updated.
// - Bitwise AND updates only the zero flag.
// - Interrupt return also sets the global interrupt enable.
// - Power-down stops clock, clears watchdog, sets powerdown, clears timeout.
`default_nettype none
`include "mieu_params.svh"
module mieu_core
  import mieu_pkg::*;
#(
  parameter int STACK_DEPTH = 6
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Program memory read port
  output var  logic [10:0] rom_addr,
  input  wire logic [13:0] rom_data,
  // Watchdog and power control
  output var  logic        wdt_clear,
  output var  logic        halt
);
  initial begin
    if (STACK_DEPTH < 1 || STACK_DEPTH > 8) $error("STACK_DEPTH must be 1 to 8");
  end

  logic [7:0]   mem_q [64];
  logic [10:0]  stk_q [STACK_DEPTH];
  logic [2:0]   sp_q;
  logic [7:0]   acc_q, madr_q;
  logic [10:0]  pc_q;
  logic [5:0]   table_high_byte_q;
  mieu_flags_t  fl_q;
  logic         gie_q, pre1_q, pre2_q, busy_q, halt_q, wdt_q;
  logic [31:0]  ir_q;
  logic [3:0]   cnt_q;
  mieu_state_t  st_q;
  logic         tab_q;
  logic [5:0]   tdst_q;

  // APB decode
  logic apb_wr, apb_rd_setup, issue;
  assign apb_wr       = psel & penable & pready & pwrite;
  assign apb_rd_setup = psel & ~penable;
  assign issue        = apb_wr & (paddr == `MIEU_OFS_INSTR) & ~busy_q & ~halt_q;

  // Instruction fields
  mieu_op_t     op;
  logic [2:0]   bsel;
  logic [5:0]   ma;
  logic [7:0]   imm;
  logic [10:0]  tgt;
  logic [7:0]   rdv;
  assign op   = mieu_op_t'(pwdata[`MIEU_F_OP_LSB +: 6]);
  assign bsel = pwdata[`MIEU_F_BIT_LSB +: 3];
  assign ma   = pwdata[`MIEU_F_MADR_LSB +: 6];
  assign imm  = pwdata[`MIEU_F_IMM_LSB +: 8];
  assign tgt  = pwdata[`MIEU_F_IMM_LSB +: 11];
  assign rdv  = (ma == `MIEU_PCL_ADDR) ? pc_q[7:0] : mem_q[ma];

  // Adder shared by add forms
  logic [7:0]  add_b;
  logic        add_ci;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  assign add_b  = (op == OP_ADDI) ? imm : rdv;
  assign add_ci = (op == OP_ADC || op == OP_ADD_WITH_CARRY_TO_MEMORY) ? fl_q.c : 1'b0;
  assign sum9   = {1'b0, acc_q} + {1'b0, add_b} + {8'h00, add_ci};
  assign sum5   = {1'b0, acc_q[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};

  // Execute decode
  logic         acc_we, m_we, skip, pc_ld, push, pop, wdt_d, halt_d, gie_set, tab_d;
  logic [7:0]   acc_wd, m_wd, inc_v, dec_v, and_v;
  logic [10:0]  pc_tgt;
  logic [1:0]   base_cyc;
  mieu_flags_t  fl_d;
  logic         pre1_d, pre2_d;
  assign inc_v = rdv + 8'h01;
  assign dec_v = rdv - 8'h01;
  assign and_v = acc_q & ((op == OP_ANDI) ? imm : rdv);

  always_comb begin
    acc_we   = 1'b0;
    acc_wd   = acc_q;
    m_we     = 1'b0;
    m_wd     = rdv;
    skip     = 1'b0;
    pc_ld    = 1'b0;
    pc_tgt   = tgt;
    push     = 1'b0;
    pop      = 1'b0;
    wdt_d    = 1'b0;
    halt_d   = 1'b0;
    gie_set  = 1'b0;
    tab_d    = 1'b0;
    base_cyc = 2'd1;
    fl_d     = fl_q;
    pre1_d   = pre1_q;
    pre2_d   = pre2_q;
    case (op)
      OP_JMP: begin
        pc_ld    = 1'b1;
        base_cyc = 2'd2;
      end
      OP_SZ:   skip = (rdv == 8'h00);
      OP_SZA: begin
        skip   = (rdv == 8'h00);
        acc_we = 1'b1;
        acc_wd = rdv;
      end
      OP_SZB:  skip = ~rdv[bsel];
      OP_SNZB: skip = rdv[bsel];
      OP_SIZ, OP_SDZ: begin
        m_we = 1'b1;
        m_wd = (op == OP_SIZ) ? inc_v : dec_v;
        skip = (m_wd == 8'h00);
      end
      OP_INCR_SKIP_RESULT_TO_ACCUMULATOR, OP_DECR_SKIP_RESULT_TO_ACCUMULATOR: begin
        acc_we = 1'b1;
        acc_wd = (op == OP_INCR_SKIP_RESULT_TO_ACCUMULATOR) ? inc_v : dec_v;
        skip   = (acc_wd == 8'h00);
      end
      OP_CALL: begin
        push     = 1'b1;
        pc_ld    = 1'b1;
        base_cyc = 2'd2;
      end
      OP_RET, OP_RETA, OP_IRQ_EXIT: begin
        pop      = 1'b1;
        pc_ld    = 1'b1;
        pc_tgt   = stk_q[(sp_q == 3'd0) ? 3'(STACK_DEPTH - 1) : sp_q - 3'd1];
        base_cyc = 2'd2;
        acc_we   = (op == OP_RETA);
        acc_wd   = imm;
        gie_set  = (op == OP_IRQ_EXIT);
      end
      OP_TABC, OP_TABL: begin
        tab_d    = 1'b1;
        base_cyc = 2'd2;
      end
      OP_CLR: begin
        m_we = 1'b1;
        m_wd = 8'h00;
      end
      OP_SET: begin
        m_we = 1'b1;
        m_wd = 8'hFF;
      end
      OP_CLRB: begin
        m_we       = 1'b1;
        m_wd[bsel] = 1'b0;
      end
      OP_WDT: begin
        wdt_d  = 1'b1;
        fl_d.to  = 1'b0;
        fl_d.powerdown_flag = 1'b0;
        pre1_d = 1'b0;
        pre2_d = 1'b0;
      end
      OP_WDT1, OP_WDT2: begin
        if ((op == OP_WDT1) ? pre2_q : pre1_q) begin
          wdt_d    = 1'b1;
          fl_d.to  = 1'b0;
          fl_d.powerdown_flag = 1'b0;
          pre1_d   = 1'b0;
          pre2_d   = 1'b0;
        end else if (op == OP_WDT1) begin
          pre1_d = 1'b1;
        end else begin
          pre2_d = 1'b1;
        end
      end
      OP_SWAP: begin
        m_we = 1'b1;
        m_wd = {rdv[3:0], rdv[7:4]};
      end
      OP_SWPA: begin
        acc_we = 1'b1;
        acc_wd = {rdv[3:0], rdv[7:4]};
      end
      OP_HALT: begin
        halt_d   = 1'b1;
        wdt_d    = 1'b1;
        fl_d.powerdown_flag = 1'b1;
        fl_d.to  = 1'b0;
      end
      OP_ADC, OP_ADD_WITH_CARRY_TO_MEMORY, OP_ADD, OP_ADDI, OP_SUM_INTO_MEMORY: begin
        acc_we  = (op != OP_ADD_WITH_CARRY_TO_MEMORY && op != OP_SUM_INTO_MEMORY);
        m_we    = ~acc_we;
        acc_wd  = sum9[7:0];
        m_wd    = sum9[7:0];
        fl_d.c  = sum9[8];
        fl_d.ac = sum5[4];
        fl_d.z  = (sum9[7:0] == 8'h00);
        fl_d.ov = (acc_q[7] == add_b[7]) & (sum9[7] != acc_q[7]);
      end
      OP_AND, OP_ANDI, OP_BITAND_INTO_MEMORY: begin
        acc_we = (op != OP_BITAND_INTO_MEMORY);
        m_we   = (op == OP_BITAND_INTO_MEMORY);
        acc_wd = and_v;
        m_wd   = and_v;
        fl_d.z = (and_v == 8'h00);
      end
      default: ;
    endcase
  end

  // Cycle length: base, taken skip, low program counter write
  logic        pcl_wr;
  logic [2:0]  mcyc;
  logic [3:0]  clk_tot;
  assign pcl_wr  = (m_we | tab_d) & (ma == `MIEU_PCL_ADDR);
  assign mcyc    = {1'b0, base_cyc} + {2'b00, skip} + {2'b00, pcl_wr};
  assign clk_tot = 4'(mcyc * `MIEU_MCYC_CLKS - 1);

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
      ir_q   <= 32'h0000_0000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (issue) begin
            st_q   <= ST_EXEC;
            cnt_q  <= clk_tot;
            busy_q <= 1'b1;
            ir_q   <= pwdata;
          end
        end
        ST_EXEC: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h0) begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Table fetch: address at issue, data taken when the instruction ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_addr <= 11'h000;
      tab_q    <= 1'b0;
      tdst_q   <= 6'h00;
      table_high_byte_q   <= 6'h00;
    end else if (issue && tab_d) begin
      rom_addr <= (op == OP_TABL) ? {3'b111, acc_q} : {pc_q[10:8], acc_q};
      tab_q    <= 1'b1;
      tdst_q   <= ma;
    end else if (tab_q && cnt_q == 4'h0) begin
      table_high_byte_q <= rom_data[13:8];
      tab_q  <= 1'b0;
    end
  end

  // Data memory
  always_ff @(posedge pclk) begin
    if (issue && m_we && ma != `MIEU_PCL_ADDR) begin
      mem_q[ma] <= m_wd;
    end else if (tab_q && cnt_q == 4'h0 && tdst_q != `MIEU_PCL_ADDR) begin
      mem_q[tdst_q] <= rom_data[7:0];
    end else if (apb_wr && paddr == `MIEU_OFS_MDATA) begin
      mem_q[madr_q[5:0]] <= pwdata[7:0];
    end
  end

  // Program counter and stack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= `MIEU_RST_PC;
      sp_q <= 3'd0;
    end else if (issue) begin
      if (pc_ld) begin
        pc_q <= pc_tgt;
      end else if (m_we && ma == `MIEU_PCL_ADDR) begin
        pc_q <= {pc_q[10:8], m_wd};
      end else begin
        pc_q <= pc_q + (skip ? 11'd2 : 11'd1);
      end
      if (push) begin
        sp_q <= (sp_q == 3'(STACK_DEPTH - 1)) ? 3'd0 : sp_q + 3'd1;
      end else if (pop) begin
        sp_q <= (sp_q == 3'd0) ? 3'(STACK_DEPTH - 1) : sp_q - 3'd1;
      end
    end else if (tab_q && cnt_q == 4'h0 && tdst_q == `MIEU_PCL_ADDR) begin
      pc_q <= {pc_q[10:8], rom_data[7:0]};
    end else if (apb_wr && paddr == `MIEU_OFS_PC && !busy_q) begin
      pc_q <= pwdata[10:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (issue && push) begin
      stk_q[sp_q] <= pc_q + 11'd1;
    end
  end

  // Accumulator, flags and control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q  <= `MIEU_RST_ACC;
      fl_q   <= `MIEU_RST_FLAGS;
      gie_q  <= 1'b0;
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
      madr_q <= 8'h00;
    end else if (issue) begin
      if (acc_we) begin
        acc_q <= acc_wd;
      end
      fl_q   <= fl_d;
      pre1_q <= pre1_d;
      pre2_q <= pre2_d;
      if (gie_set) begin
        gie_q <= 1'b1;
      end
    end else if (apb_wr && !busy_q) begin
      case (paddr)
        `MIEU_OFS_ACC:   acc_q <= pwdata[7:0];
        `MIEU_OFS_MADDR: madr_q <= {2'b00, pwdata[5:0]};
        `MIEU_OFS_STATUS: begin
          fl_q.ov <= pwdata[3];
          fl_q.z  <= pwdata[2];
          fl_q.ac <= pwdata[1];
          fl_q.c  <= pwdata[0];
          gie_q   <= pwdata[`MIEU_ST_GIE];
        end
        default: ;
      endcase
    end
  end

  // Watchdog clear pulse and power-down state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_q  <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      wdt_q <= issue & wdt_d;
      if (issue && halt_d) begin
        halt_q <= 1'b1;
      end else if (apb_wr && paddr == `MIEU_OFS_STATUS && pwdata[`MIEU_ST_HALT]) begin
        halt_q <= 1'b0;
      end
    end
  end
  assign wdt_clear = wdt_q;
  assign halt      = halt_q;

  // APB answer, one clock after setup
  logic [31:0] rd_d;
  logic        err_d;
  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `MIEU_OFS_INSTR:  rd_d = ir_q;
      `MIEU_OFS_STATUS: rd_d = {20'h00000, pre2_q, pre1_q, halt_q, busy_q, 1'b0, gie_q, fl_q};
      `MIEU_OFS_ACC:    rd_d = {24'h000000, acc_q};
      `MIEU_OFS_PC:     rd_d = {21'h000000, pc_q};
      `MIEU_OFS_TABLE_HIGH_BYTE:   rd_d = {26'h0000000, table_high_byte_q};
      `MIEU_OFS_MADDR:  rd_d = {24'h000000, madr_q};
      `MIEU_OFS_MDATA:  rd_d = {24'h000000, mem_q[madr_q[5:0]]};
      default:          err_d = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_rd_setup;
      pslverr <= apb_rd_setup & err_d;
      prdata  <= (apb_rd_setup && !pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  jump_two_cycles_a: assert property (issue && op == OP_JMP |=> busy_q [*8] ##1 !busy_q)
    else $error("jump did not take two machine cycles");
  skip_extra_cycle_a: assert property (issue && op == OP_SZ && rdv == 8'h00
      && ma != `MIEU_PCL_ADDR |=> busy_q [*8] ##1 !busy_q)
    else $error("taken skip did not add one machine cycle");
  skip_pc_step_a: assert property (issue && skip && !pc_ld |=> pc_q == ($past(pcl_wr)
      ? {$past(pc_q[10:8]), $past(m_wd)} : $past(pc_q) + 11'd2))
    else $error("taken skip did not step over the next instruction");
  pcl_extra_cycle_a: assert property (issue && op == OP_CLR
      && ma == `MIEU_PCL_ADDR |=> busy_q [*8] ##1 !busy_q)
    else $error("low program counter write did not add a cycle");
  call_push_load_a: assert property (issue && op == OP_CALL |=> pc_q == $past(tgt)
      && stk_q[$past(sp_q)] == $past(pc_q) + 11'd1)
    else $error("call did not push return address and load target");
  irq_exit_gie_a: assert property (issue && op == OP_IRQ_EXIT |=> gie_q)
    else $error("interrupt return did not enable interrupts");
  wdt_clear_flags_a: assert property (issue && op == OP_WDT |=> wdt_clear && !fl_q.to
      && !fl_q.powerdown_flag ##1 !wdt_clear)
    else $error("watchdog clear did not clear flags or pulse once");
  halt_entry_a: assert property (issue && op == OP_HALT |=> halt && fl_q.powerdown_flag && !fl_q.to
      && wdt_clear)
    else $error("power-down entry wrong");
  and_flags_kept_a: assert property (issue && op == OP_AND |=> fl_q.c == $past(fl_q.c)
      && fl_q.ov == $past(fl_q.ov) && fl_q.ac == $past(fl_q.ac))
    else $error("AND touched flags other than zero");
  add_result_a: assert property (issue && op == OP_ADD |=> acc_q == $past(sum9[7:0])
      && fl_q.c == $past(sum9[8]))
    else $error("add result or carry wrong");
  clr_flags_kept_a: assert property (issue && op == OP_CLR |=> fl_q == $past(fl_q))
    else $error("clear touched flags");

  skip_taken_c: cover property (issue && skip);
  table_fetch_c: cover property (issue && tab_d ##[1:12] !busy_q);
  preclear_pair_c: cover property (issue && op == OP_WDT2 && pre1_q);
  call_return_c: cover property (issue && op == OP_CALL ##[1:40] issue && op == OP_RET);
endmodule
`default_nettype wire

/* bench/mcu_instruction_execute_unit_tb.sv */
/*
  Self-checking bench for the instruction execute unit, driven over APB.
  Assumes mieu_pkg and mieu_params.svh compiled first; program memory modelled here.
*/
`default_nettype none
`include "mieu_params.svh"
module mcu_instruction_execute_unit_tb
  import mieu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [10:0] rom_addr;
  logic [13:0] rom_data = 14'h0;
  logic        wdt_clear;
  logic        halt;
  int          miscompares = 0;
  int          n_compared  = 0;
  int          cyc = 0;
  int          wcnt = 0;
  int          t_set = 0;
  int          t_acc = 0;

  mieu_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data),
    .wdt_clear(wdt_clear), .halt(halt));

  initial begin
    forever #5 pclk = ~pclk;
  end

  // Program memory word depends on its address
  function automatic logic [13:0] romf(input logic [10:0] a);
    return {a[10:5], ~a[7:0]};
  endfunction

  always_ff @(posedge pclk) begin
    rom_data <= romf(rom_addr);
    cyc <= cyc + 1;
    if (wdt_clear === 1'b1) wcnt <= wcnt + 1;
  end

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    t_set = cyc;
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      print_verdict();
    end
    t_acc = cyc;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rm(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r & mask, x);
  endtask

  task automatic setm(input logic [5:0] a, input logic [7:0] v);
    wr(`MIEU_OFS_MADDR, {26'h0, a});
    wr(`MIEU_OFS_MDATA, {24'h0, v});
  endtask

  task automatic mm(input logic [5:0] a, input logic [7:0] x);
    wr(`MIEU_OFS_MADDR, {26'h0, a});
    rm(`MIEU_OFS_MDATA, 32'hFF, {24'h0, x});
  endtask

  // Issue one instruction, wait for busy to fall, check machine cycles used
  task automatic ex(input mieu_op_t op, input logic [5:0] m, input logic [10:0] t,
                    input logic [2:0] b, input int mc);
    int          ti;
    int          th;
    int          i;
    logic [31:0] r;
    logic        e;
    xfer(1'b1, `MIEU_OFS_INSTR, {5'h00, t, m, 1'b0, b, op}, r, e);
    ti = t_acc;
    th = t_acc;
    for (i = 0; i < 40; i++) begin
      xfer(1'b0, `MIEU_OFS_STATUS, 32'h0, r, e);
      if (r[`MIEU_ST_BUSY] === 1'b0) break;
      th = t_set;
    end
    if (i == 40) begin
      miscompares++;
      print_verdict();
    end
    // Last busy sample and first idle sample bracket 4*mc clocks after issue
    chk(32'((th - ti <= 4 * mc) && (t_set - ti > 4 * mc)), 32'h1);
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rm(`MIEU_OFS_STATUS, 32'hFFF, 32'h0);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h0);
    xfer(1'b0, 8'h1C, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    setm(6'h05, 8'h00);
    ex(OP_SZ, 6'h05, 11'h0, 3'h0, 2);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h2);
    setm(6'h05, 8'h10);
    ex(OP_SZ, 6'h05, 11'h0, 3'h0, 1);
    ex(OP_SZB, 6'h05, 11'h0, 3'h4, 1);
    ex(OP_SNZB, 6'h05, 11'h0, 3'h4, 2);
    ex(OP_SZA, 6'h05, 11'h0, 3'h0, 1);
    rm(`MIEU_OFS_ACC, 32'hFF, 32'h10);
    setm(6'h07, 8'hFF);
    ex(OP_SIZ, 6'h07, 11'h0, 3'h0, 2);
    mm(6'h07, 8'h00);
    setm(6'h08, 8'h01);
    ex(OP_DECR_SKIP_RESULT_TO_ACCUMULATOR, 6'h08, 11'h0, 3'h0, 2);
    rm(`MIEU_OFS_ACC, 32'hFF, 32'h0);
    ex(OP_INCR_SKIP_RESULT_TO_ACCUMULATOR, 6'h08, 11'h0, 3'h0, 1);
    rm(`MIEU_OFS_ACC, 32'hFF, 32'h2);
    mm(6'h08, 8'h01);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h0C);
    setm(6'h10, 8'h02);
    ex(OP_SDZ, 6'h10, 11'h0, 3'h0, 1);
    mm(6'h10, 8'h01);
    wr(`MIEU_OFS_STATUS, 32'h5);
    ex(OP_JMP, 6'h00, 11'h1C3, 3'h0, 2);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h1C3);
    ex(OP_CLR, `MIEU_PCL_ADDR, 11'h0, 3'h0, 2);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h100);
    setm(6'h09, 8'hFF);
    ex(OP_CLR, 6'h09, 11'h0, 3'h0, 1);
    mm(6'h09, 8'h00);
    setm(6'h09, 8'hFF);
    ex(OP_CLRB, 6'h09, 11'h0, 3'h3, 1);
    mm(6'h09, 8'hF7);
    rm(`MIEU_OFS_STATUS, 32'h7F, 32'h05);
    ex(OP_CALL, 6'h00, 11'h2AA, 3'h0, 2);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h2AA);
    ex(OP_RET, 6'h00, 11'h0, 3'h0, 2);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h103);
    ex(OP_CALL, 6'h00, 11'h300, 3'h0, 2);
    ex(OP_IRQ_EXIT, 6'h00, 11'h0, 3'h0, 2);
    rm(`MIEU_OFS_STATUS, 32'h7F, 32'h45);
    ex(OP_CALL, 6'h00, 11'h055, 3'h0, 2);
    ex(OP_RETA, 6'h00, 11'h0C3, 3'h0, 2);
    rm(`MIEU_OFS_ACC, 32'hFF, 32'hC3);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h105);
    ex(OP_JMP, 6'h00, 11'h101, 3'h0, 2);
    ex(OP_SDZ, `MIEU_PCL_ADDR, 11'h0, 3'h0, 3);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h100);
    ex(OP_SET, `MIEU_PCL_ADDR, 11'h0, 3'h0, 2);
    rm(`MIEU_OFS_PC, 32'h7FF, 32'h1FF);
    ex(OP_TABC, 6'h0A, 11'h0, 3'h0, 2);
    mm(6'h0A, 8'(romf(11'h1C3)));
    rm(`MIEU_OFS_TABLE_HIGH_BYTE, 32'h3F, 32'(romf(11'h1C3) >> 8));
    ex(OP_TABL, 6'h0B, 11'h0, 3'h0, 2);
    mm(6'h0B, 8'(romf(11'h7C3)));
    rm(`MIEU_OFS_TABLE_HIGH_BYTE, 32'h3F, 32'(romf(11'h7C3) >> 8));
    setm(6'h0C, 8'h5A);
    ex(OP_SWPA, 6'h0C, 11'h0, 3'h0, 1);
    rm(`MIEU_OFS_ACC, 32'hFF, 32'hA5);
    mm(6'h0C, 8'h5A);
    ex(OP_SWAP, 6'h0C, 11'h0, 3'h0, 1);
    mm(6'h0C, 8'hA5);
    wr(`MIEU_OFS_STATUS, 32'h0);
    wr(`MIEU_OFS_ACC, 32'h7F);
    setm(6'h0D, 8'h01);
    setm(6'h0E, 8'h7F);
    setm(6'h0F, 8'h7E);
    ex(OP_ADD, 6'h0D, 11'h0, 3'h0, 1);
    rm(`MIEU_OFS_STATUS, 32'h3F, 32'h0A);
    ex(OP_ADDI, 6'h00, 11'h0FF, 3'h0, 1);
    rm(`MIEU_OFS_ACC, 32'hFF, 32'h7F);
    rm(`MIEU_OFS_STATUS, 32'h3F, 32'h09);
    ex(OP_ADC, 6'h0D, 11'h0, 3'h0, 1);
    rm(`MIEU_OFS_ACC, 32'hFF, 32'h81);
    rm(`MIEU_OFS_STATUS, 32'h3F, 32'h0A);
    ex(OP_ADD_WITH_CARRY_TO_MEMORY, 6'h0D, 11'h0, 3'h0, 1);
    mm(6'h0D, 8'h82);
    rm(`MIEU_OFS_STATUS, 32'h3F, 32'h00);
    ex(OP_AND, 6'h0F, 11'h0, 3'h0, 1);
    rm(`MIEU_OFS_STATUS, 32'hFF, 32'h04);
    wr(`MIEU_OFS_ACC, 32'hFF);
    ex(OP_ANDI, 6'h00, 11'h03C, 3'h0, 1);
    rm(`MIEU_OFS_ACC, 32'hFF, 32'h3C);
    ex(OP_BITAND_INTO_MEMORY, 6'h0D, 11'h0, 3'h0, 1);
    mm(6'h0D, 8'h00);
    ex(OP_SUM_INTO_MEMORY, 6'h0E, 11'h0, 3'h0, 1);
    mm(6'h0E, 8'hBB);
    rm(`MIEU_OFS_STATUS, 32'h3F, 32'h0A);
    ex(OP_HALT, 6'h00, 11'h0, 3'h0, 1);
    chk({31'h0, halt}, 32'h1);
    chk(32'(wcnt), 32'h1);
    rm(`MIEU_OFS_STATUS, 32'h3F, 32'h1A);
    wr(`MIEU_OFS_STATUS, 32'h20A);
    chk({31'h0, halt}, 32'h0);
    ex(OP_WDT1, 6'h00, 11'h0, 3'h0, 1);
    ex(OP_WDT1, 6'h00, 11'h0, 3'h0, 1);
    rm(`MIEU_OFS_STATUS, 32'h30, 32'h10);
    chk(32'(wcnt), 32'h1);
    ex(OP_WDT2, 6'h00, 11'h0, 3'h0, 1);
    rm(`MIEU_OFS_STATUS, 32'h30, 32'h00);
    chk(32'(wcnt), 32'h2);
    ex(OP_HALT, 6'h00, 11'h0, 3'h0, 1);
    wr(`MIEU_OFS_STATUS, 32'h20A);
    ex(OP_WDT, 6'h00, 11'h0, 3'h0, 1);
    rm(`MIEU_OFS_STATUS, 32'h3F, 32'h0A);
    chk(32'(wcnt), 32'h4);
    print_verdict();
  end
endmodule
`default_nettype wire
